//--- core/cms_pkg.sv
// Constants, register map and carrier types for the modem timing and ranging core.
// Assumes one 200 MHz clock and a plain register port.
package cms_pkg;

  // Widths
  localparam int TS_W   = 32;
  localparam int MS_W   = 32;
  localparam int SID_W  = 14;
  localparam int IUC_W  = 4;
  localparam int PROF_W = 4;
  localparam int ML_W   = 3;
  localparam int PID_W  = 13;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Timing: clock period, base tick 6,25 us, 64 fine steps per tick
  localparam int CLK_NS        = 5;
  localparam int TICK_NS       = 6250;
  localparam int FRAC_PER_TICK = 64;
  localparam int FRAC_BITS     = 6;
  localparam int MS_TOP_BIT    = 26;
  localparam logic [15:0] PHASE_STEP = 16'(CLK_NS * FRAC_PER_TICK);
  localparam logic [15:0] PHASE_WRAP = 16'(TICK_NS);
  localparam logic signed [7:0] TRIM_MAX = 8'sh3F;

  // Lost sync interval in microseconds; arbitrary default
  localparam int LOST_SYNC_US  = 600000;
  localparam int LOST_SYNC_CYC = LOST_SYNC_US * (1000 / CLK_NS);

  // Acquisition and ranging
  localparam logic [1:0]       SYNC_MIN       = 2'h2;
  localparam logic [SID_W-1:0] SID_UNINIT     = 14'h0000;
  localparam logic [IUC_W-1:0] IUC_INIT_MAINT = 4'h3;
  localparam logic [IUC_W-1:0] IUC_STA_MAINT  = 4'h4;
  localparam logic [PID_W-1:0] PID_MAC_DEF    = 13'h1FFE;
  localparam logic [1:0]       RSP_CONTINUE   = 2'h1;
  localparam logic [1:0]       RSP_ABORT      = 2'h2;
  localparam logic [1:0]       RSP_SUCCESS    = 2'h3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FIX_DLY  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TOL      = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_OFFSET   = 8'h10;
  localparam logic [ADDR_W-1:0] REG_LOCAL_TS = 8'h14;
  localparam logic [ADDR_W-1:0] REG_SYNC_ERR = 8'h18;
  localparam logic [ADDR_W-1:0] REG_SID      = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_MSLOT    = 8'h20;

  // Control fields and reset values
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam logic              CTRL_EN_RST = 1'b1;
  localparam logic [DATA_W-1:0] FIX_DLY_RST = 32'h0000_0040;
  localparam logic [DATA_W-1:0] TOL_RST     = 32'h0000_0010;

  typedef enum logic [3:0] {
    ST_PHY_WAIT, ST_SYNC_ACQ, ST_UCD_WAIT, ST_MAP_SCAN,
    ST_RNG_TX, ST_RSP_WAIT, ST_STA_WAIT, ST_OPER
  } cms_state_t;

  typedef struct packed {
    logic freq_lock;
    logic equalized;
    logic framing;
    logic fec_ok;
  } cms_phy_t;

  typedef struct packed {
    logic [IUC_W-1:0] iuc;
    logic [SID_W-1:0] sid;
    logic [MS_W-1:0]  mslot;
  } cms_ie_t;

  typedef struct packed {
    logic [SID_W-1:0] sid;
    logic [1:0]       status;
    logic [TS_W-1:0]  timing_adj;
    logic [7:0]       power_adj;
    logic [15:0]      freq_adj;
  } cms_rsp_t;

endpackage

//--- core/cms_timing_sync.sv
// Downstream sync tracking, acquisition sequencing, ranging and burst launch timing.
// Assumes all inputs are synchronous to ref_clk_i and already decoded messages.
`timescale 1ns/1ps
module cms_timing_sync
  import cms_pkg::*;
#(
  parameter int               LOST_CYC = LOST_SYNC_CYC,
  parameter logic [PID_W-1:0] PID_MAC  = PID_MAC_DEF
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Physical layer status
  input  wire cms_phy_t          phy_i,
  // Transport packets
  input  wire logic              pkt_valid_i,
  input  wire logic [PID_W-1:0]  pkt_pid_i,
  input  wire logic              pkt_pusi_i,
  output logic                   mac_start_o,
  // SYNC messages
  input  wire logic              sync_valid_i,
  input  wire logic [TS_W-1:0]   sync_ts_i,
  // Channel descriptor
  input  wire logic              ucd_valid_i,
  input  wire logic [ML_W-1:0]   ucd_mslot_log2_i,
  input  wire logic              ucd_prof_we_i,
  input  wire logic [IUC_W-1:0]  ucd_prof_iuc_i,
  input  wire logic [PROF_W-1:0] ucd_prof_i,
  // MAP elements and ranging responses
  input  wire logic              ie_valid_i,
  input  wire cms_ie_t           ie_i,
  input  wire logic              rsp_valid_i,
  input  wire cms_rsp_t          rsp_i,
  // Upstream burst launch
  output logic                   tx_start_o,
  output logic                   tx_ranging_o,
  output logic      [SID_W-1:0]  tx_sid_o,
  output logic      [IUC_W-1:0]  tx_iuc_o,
  output logic      [PROF_W-1:0] tx_profile_o,
  output logic      [7:0]        tx_power_adj_o,
  output logic      [15:0]       tx_freq_adj_o,
  // Status
  output logic                   synced_o,
  output logic                   ranged_o,
  output logic      [MS_W-1:0]   mslot_o
);

  cms_state_t        state;
  logic              enable;
  logic [DATA_W-1:0] fixed_delay;
  logic [DATA_W-1:0] tol;
  logic [TS_W-1:0]   ts;
  logic [15:0]       phase;
  logic signed [7:0] trim;
  logic [TS_W-1:0]   sync_err;
  logic [1:0]        sync_cnt;
  logic [31:0]       lost_cnt;
  logic [ML_W-1:0]   mslot_log2;
  logic [PROF_W-1:0] prof_tab [2**IUC_W];
  logic [TS_W-1:0]   offset;
  logic [SID_W-1:0]  temp_sid;
  logic              pend;
  logic [TS_W-1:0]   pend_ts;
  logic [SID_W-1:0]  pend_sid;
  logic [IUC_W-1:0]  pend_iuc;
  logic              pend_rng;

  logic              phy_ok;
  logic              sync_ok;
  logic              lost;
  logic              restart;
  logic              tx_allowed;
  logic              fire;
  logic              in_tol;
  logic              ie_hit;
  logic              ie_rng;
  logic              rsp_take;
  logic [15:0]       phase_sum;
  logic signed [TS_W-1:0] err;
  logic signed [TS_W-1:0] lead;
  logic [TS_W-1:0]   slot_ts;
  logic [DATA_W-1:0] next_rdata;

  assign phy_ok  = phy_i.freq_lock & phy_i.equalized & phy_i.framing & phy_i.fec_ok;
  assign sync_ok = sync_valid_i & phy_ok & (state != ST_PHY_WAIT);
  assign err     = $signed(sync_ts_i - ts);
  assign in_tol  = (err <= $signed(tol)) && (err >= -$signed(tol));
  assign lost    = (lost_cnt >= 32'(LOST_CYC - 1)) && !sync_ok;
  assign restart = reg_wr_i && (reg_addr_i == REG_CTRL) && reg_wdata_i[CTRL_RST_BIT];
  assign tx_allowed = enable && (sync_cnt >= SYNC_MIN) && (state > ST_SYNC_ACQ);
  assign lead    = $signed(ts - pend_ts);
  assign fire    = pend && tx_allowed && !lost && (lead >= 0);
  assign phase_sum = phase + PHASE_STEP + 16'($signed(trim));
  assign slot_ts = TS_W'(ie_i.mslot << (5'(mslot_log2) + 5'(FRAC_BITS)));
  assign rsp_take = rsp_valid_i && ((state == ST_RSP_WAIT) ||
                    ((state == ST_OPER) && (rsp_i.sid == temp_sid)));
  assign synced_o = tx_allowed;
  assign ranged_o = (state == ST_OPER);

  // Interval element selection per acquisition step
  always_comb begin
    ie_hit = 1'b0;
    ie_rng = 1'b0;
    if (ie_valid_i && !pend) begin
      case (state)
        ST_MAP_SCAN: begin
          ie_hit = (ie_i.iuc == IUC_INIT_MAINT);
          ie_rng = 1'b1;
        end
        ST_STA_WAIT: begin
          ie_hit = (ie_i.iuc == IUC_STA_MAINT) && (ie_i.sid == temp_sid);
          ie_rng = 1'b1;
        end
        ST_OPER: begin
          ie_hit = (ie_i.sid == temp_sid) && (ie_i.iuc != IUC_INIT_MAINT);
          ie_rng = (ie_i.iuc == IUC_STA_MAINT);
        end
        default: ie_hit = 1'b0;
      endcase
    end
  end

  // Control, fixed delay and tolerance registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable      <= CTRL_EN_RST;
      fixed_delay <= FIX_DLY_RST;
      tol         <= TOL_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        REG_CTRL:    enable      <= reg_wdata_i[CTRL_EN_BIT];
        REG_FIX_DLY: fixed_delay <= reg_wdata_i;
        REG_TOL:     tol         <= reg_wdata_i;
        default:     enable      <= enable;
      endcase
    end
  end

  // Local timestamp and clock trim
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ts       <= '0;
      phase    <= '0;
      trim     <= '0;
      sync_err <= '0;
    end else if (sync_ok) begin
      ts       <= sync_ts_i;
      phase    <= '0;
      sync_err <= err;
      if (err > 0 && trim < TRIM_MAX)
        trim <= trim + 8'sh01;
      else if (err < 0 && trim > -TRIM_MAX)
        trim <= trim - 8'sh01;
    end else if (phase_sum >= PHASE_WRAP) begin
      phase <= phase_sum - PHASE_WRAP;
      ts    <= ts + 32'h0000_0001;
    end else begin
      phase <= phase_sum;
    end
  end

  // SYNC count and lost sync timer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_cnt <= '0;
      lost_cnt <= '0;
    end else if (!phy_ok || restart || (state == ST_PHY_WAIT)) begin
      sync_cnt <= '0;
      lost_cnt <= '0;
    end else if (sync_ok) begin
      lost_cnt <= '0;
      if (sync_cnt == 2'h0 || !in_tol)
        sync_cnt <= 2'h1;
      else if (sync_cnt < SYNC_MIN)
        sync_cnt <= sync_cnt + 2'h1;
    end else if (lost) begin
      sync_cnt <= '0;
      lost_cnt <= '0;
    end else if (sync_cnt != 2'h0) begin
      lost_cnt <= lost_cnt + 32'h0000_0001;
    end
  end

  // Acquisition and ranging sequence
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_PHY_WAIT;
    end else if (!phy_ok || restart) begin
      state <= ST_PHY_WAIT;
    end else if (lost) begin
      state <= ST_SYNC_ACQ;
    end else begin
      case (state)
        ST_PHY_WAIT: state <= ST_SYNC_ACQ;
        ST_SYNC_ACQ: if (sync_cnt >= SYNC_MIN) state <= ST_UCD_WAIT;
        ST_UCD_WAIT: if (ucd_valid_i) state <= ST_MAP_SCAN;
        ST_MAP_SCAN: if (ie_hit) state <= ST_RNG_TX;
        ST_STA_WAIT: if (ie_hit) state <= ST_RNG_TX;
        ST_RNG_TX:   if (fire) state <= ST_RSP_WAIT;
        ST_RSP_WAIT: if (rsp_take) begin
          case (rsp_i.status)
            RSP_SUCCESS: state <= ST_OPER;
            RSP_ABORT:   state <= ST_MAP_SCAN;
            default:     state <= ST_STA_WAIT;
          endcase
        end
        ST_OPER: if (rsp_take && rsp_i.status == RSP_ABORT) state <= ST_MAP_SCAN;
        default: state <= ST_PHY_WAIT;
      endcase
    end
  end

  // Ranged timing offset, temporary SID and transmit corrections
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      offset         <= '0;
      temp_sid       <= SID_UNINIT;
      tx_power_adj_o <= '0;
      tx_freq_adj_o  <= '0;
    end else if ((state == ST_UCD_WAIT) || (rsp_take && rsp_i.status == RSP_ABORT)) begin
      offset   <= fixed_delay;
      temp_sid <= SID_UNINIT;
    end else if (rsp_take) begin
      offset         <= offset + rsp_i.timing_adj;
      tx_power_adj_o <= tx_power_adj_o + rsp_i.power_adj;
      tx_freq_adj_o  <= tx_freq_adj_o + rsp_i.freq_adj;
      if (state == ST_RSP_WAIT)
        temp_sid <= rsp_i.sid;
    end
  end

  // Channel descriptor: mini-slot multiplier and burst profile table
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mslot_log2 <= '0;
    end else if (ucd_valid_i) begin
      mslot_log2 <= ucd_mslot_log2_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (ucd_prof_we_i) begin
      prof_tab[ucd_prof_iuc_i] <= ucd_prof_i;
    end
  end

  // Pending burst, launched at its ranged start time
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend     <= 1'b0;
      pend_ts  <= '0;
      pend_sid <= '0;
      pend_iuc <= '0;
      pend_rng <= 1'b0;
    end else if (!tx_allowed || lost) begin
      pend <= 1'b0;
    end else if (ie_hit) begin
      pend     <= 1'b1;
      pend_ts  <= slot_ts - offset;
      pend_iuc <= ie_i.iuc;
      pend_rng <= ie_rng;
      pend_sid <= (state == ST_MAP_SCAN) ? SID_UNINIT : temp_sid;
    end else if (fire) begin
      pend <= 1'b0;
    end
  end

  // Burst launch outputs
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_start_o   <= 1'b0;
      tx_ranging_o <= 1'b0;
      tx_sid_o     <= '0;
      tx_iuc_o     <= '0;
      tx_profile_o <= '0;
    end else begin
      tx_start_o <= fire;
      if (fire) begin
        tx_ranging_o <= pend_rng;
        tx_sid_o     <= pend_sid;
        tx_iuc_o     <= pend_iuc;
        tx_profile_o <= prof_tab[pend_iuc];
      end
    end
  end

  // MAC frame delivery from the convergence layer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mac_start_o <= 1'b0;
    end else begin
      mac_start_o <= pkt_valid_i && phy_ok && pkt_pusi_i && (pkt_pid_i == PID_MAC);
    end
  end

  // Mini-slot count from the timestamp, upper bits held at zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mslot_o <= '0;
    end else begin
      mslot_o <= MS_W'(ts >> (5'(mslot_log2) + 5'(FRAC_BITS)));
    end
  end

  // Register read, data in the following cycle only
  always_comb begin
    next_rdata = '0;
    case (reg_addr_i)
      REG_CTRL:     next_rdata[CTRL_EN_BIT] = enable;
      REG_STATUS:   next_rdata = {24'h000000, ranged_o, synced_o, phy_ok, 1'b0, state};
      REG_FIX_DLY:  next_rdata = fixed_delay;
      REG_TOL:      next_rdata = tol;
      REG_OFFSET:   next_rdata = offset;
      REG_LOCAL_TS: next_rdata = ts;
      REG_SYNC_ERR: next_rdata = sync_err;
      REG_SID:      next_rdata = {18'h00000, temp_sid};
      REG_MSLOT:    next_rdata = mslot_o;
      default:      next_rdata = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : '0;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sync_reload_a: assert property (sync_ok |=> ts == $past(sync_ts_i))
    else $error("local timestamp not reloaded by SYNC");
  tx_gate_a: assert property (tx_start_o |-> $past(sync_cnt) >= SYNC_MIN)
    else $error("burst launched while not synchronized");
  phy_first_a: assert property (!phy_ok |=> state == ST_PHY_WAIT ##1 !tx_start_o)
    else $error("sequence ran without physical lock");
  mac_pid_a: assert property (mac_start_o |-> $past(pkt_pid_i) == PID_MAC && $past(pkt_pusi_i))
    else $error("MAC frame passed on wrong PID or no payload start");
  sync_two_a: assert property (state == ST_SYNC_ACQ ##1 state == ST_UCD_WAIT
    |-> $past(sync_cnt) == SYNC_MIN)
    else $error("sync declared before two good SYNC messages");
  lost_sync_a: assert property (lost && phy_ok && !restart
    |=> state == ST_SYNC_ACQ && !pend ##1 !tx_start_o)
    else $error("lost sync did not restart acquisition");
  init_sid_a: assert property (tx_start_o && tx_iuc_o == IUC_INIT_MAINT
    |-> tx_sid_o == SID_UNINIT && tx_ranging_o)
    else $error("initial ranging not sent with SID zero");
  offset_load_a: assert property (state == ST_UCD_WAIT ##1 state == ST_MAP_SCAN
    |-> offset == $past(fixed_delay))
    else $error("timing offset not loaded with fixed delay");
  success_oper_a: assert property (state == ST_RSP_WAIT && rsp_take && rsp_i.status == RSP_SUCCESS
    && phy_ok && !restart && !lost |=> ranged_o)
    else $error("ranging success did not enter data traffic");
  mslot_top_a: assert property ((mslot_o >> (MS_TOP_BIT - $past(mslot_log2))) == '0)
    else $error("unused mini-slot bits not zero");
  launch_time_a: assert property (tx_start_o |-> $past(lead) >= 0 && $past(lead) < 64)
    else $error("burst launched before its ranged start time");

  synced_c: cover property (state == ST_SYNC_ACQ ##1 state == ST_UCD_WAIT);
  ranged_c: cover property (state == ST_RSP_WAIT ##1 state == ST_OPER);
  lost_c:   cover property (lost && state == ST_OPER);
  data_c:   cover property (tx_start_o && !tx_ranging_o);

endmodule

//--- sim/cms_head_end.sv
// Head-end model: SYNC source, head-end time base and ranging responder.
// Assumes the modem core shares the 200 MHz clock and the line has no delay.
`timescale 1ns/1ps
module cms_head_end
  import cms_pkg::*;
#(
  parameter int               SYNC_GAP = 400,
  parameter int               RSP_DLY  = 50,
  parameter logic [SID_W-1:0] TEMP_SID = 14'h0155,
  parameter logic [TS_W-1:0]  ADJ      = 32'h0000_0010
) (
  // Clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  // Control and upstream bursts
  input  wire logic            sync_en_i,
  input  wire logic            tx_start_i,
  input  wire logic            tx_ranging_i,
  // Downstream messages
  output logic                 sync_valid_o,
  output logic      [TS_W-1:0] sync_ts_o,
  output logic                 rsp_valid_o,
  output cms_rsp_t             rsp_o,
  // Head-end time
  output logic      [TS_W-1:0] ts_o
);
  logic [15:0] phase;
  int          gap_cnt;
  int          rsp_cnt;
  logic        rsp_done;

  // Fine time base, 64 steps per tick
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= 16'h0000;
      ts_o  <= 32'h0000_0000;
    end else if (phase + PHASE_STEP >= PHASE_WRAP) begin
      phase <= phase + PHASE_STEP - PHASE_WRAP;
      ts_o  <= ts_o + 32'h1;
    end else begin
      phase <= phase + PHASE_STEP;
    end
  end

  // Periodic SYNC carrying its send instant; line toggles when idle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_cnt      <= 0;
      sync_valid_o <= 1'b0;
      sync_ts_o    <= 32'h0000_0000;
    end else begin
      gap_cnt      <= (gap_cnt == SYNC_GAP - 1) ? 0 : gap_cnt + 1;
      sync_valid_o <= sync_en_i && gap_cnt == SYNC_GAP - 1;
      sync_ts_o    <= (sync_en_i && gap_cnt == SYNC_GAP - 1) ? ts_o : ~sync_ts_o;
    end
  end

  // One response per ranging burst: continue first, success after
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_cnt     <= 0;
      rsp_done    <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
    end else begin
      rsp_valid_o <= rsp_cnt == 1;
      rsp_o       <= ~rsp_o;
      if (tx_start_i && tx_ranging_i) begin
        rsp_cnt <= RSP_DLY;
      end else if (rsp_cnt > 0) begin
        rsp_cnt <= rsp_cnt - 1;
      end
      if (rsp_cnt == 1) begin
        rsp_done <= 1'b1;
        rsp_o    <= '{sid: TEMP_SID, status: rsp_done ? RSP_SUCCESS : RSP_CONTINUE,
                      timing_adj: ADJ, power_adj: 8'h05, freq_adj: 16'h0100};
      end
    end
  end
endmodule

//--- sim/cms_timing_sync_tb_top.sv
// Testbench for the modem timing, acquisition and ranging core.
// Assumes the head-end model supplies SYNC messages and ranging responses.
`timescale 1ns/1ps
module cms_timing_sync_tb_top
  import cms_pkg::*;
();
  localparam int LOST = 2000;
  logic              ref_clk_i = 1'b0, rst_n_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0, reg_rdata_o, d;
  logic              reg_wr_i = 1'b0, reg_rd_i = 1'b0, mac_start_o;
  cms_phy_t          phy_i = '0;
  logic              pkt_valid_i = 1'b0, pkt_pusi_i = 1'b0;
  logic [PID_W-1:0]  pkt_pid_i = '0;
  logic              sync_valid_i, rsp_valid_i, sync_en = 1'b1;
  logic [TS_W-1:0]   sync_ts_i, he_ts, ts0;
  logic              ucd_valid_i = 1'b0, ucd_prof_we_i = 1'b0, ie_valid_i = 1'b0;
  logic [ML_W-1:0]   ucd_mslot_log2_i = 3'h2;
  logic [IUC_W-1:0]  ucd_prof_iuc_i = '0, tx_iuc_o;
  logic [PROF_W-1:0] ucd_prof_i = '0, tx_profile_o;
  cms_ie_t           ie_i = '0;
  cms_rsp_t          rsp_i;
  logic              tx_start_o, tx_ranging_o, synced_o, ranged_o;
  logic [SID_W-1:0]  tx_sid_o;
  logic [7:0]        tx_power_adj_o;
  logic [15:0]       tx_freq_adj_o;
  logic [MS_W-1:0]   mslot_o;
  int                miscompares = 0, samples_checked = 0, n_tx = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  cms_timing_sync #(.LOST_CYC(LOST), .PID_MAC(PID_MAC_DEF)) uut (
    .ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .phy_i, .pkt_valid_i, .pkt_pid_i, .pkt_pusi_i, .mac_start_o, .sync_valid_i, .sync_ts_i,
    .ucd_valid_i, .ucd_mslot_log2_i, .ucd_prof_we_i, .ucd_prof_iuc_i, .ucd_prof_i, .ie_valid_i,
    .ie_i, .rsp_valid_i, .rsp_i, .tx_start_o, .tx_ranging_o, .tx_sid_o, .tx_iuc_o,
    .tx_profile_o, .tx_power_adj_o, .tx_freq_adj_o, .synced_o, .ranged_o, .mslot_o
  );
  cms_head_end he (
    .ref_clk_i, .rst_n_i, .sync_en_i(sync_en), .tx_start_i(tx_start_o),
    .tx_ranging_i(tx_ranging_o), .sync_valid_o(sync_valid_i), .sync_ts_o(sync_ts_i),
    .rsp_valid_o(rsp_valid_i), .rsp_o(rsp_i), .ts_o(he_ts)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic wait_hi(input int k, input int lim);
    int   n;
    logic s;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
      s = (k == 0) ? sync_valid_i : (k == 1) ? tx_start_o : rsp_valid_i;
    end while (s !== 1'b1 && n < lim);
    check("wait", s, 1'b1);
  endtask

  task automatic send_pkt(input logic [PID_W-1:0] pid, input logic pusi, input logic exp);
    @(posedge ref_clk_i);
    pkt_valid_i <= 1'b1;
    pkt_pid_i   <= pid;
    pkt_pusi_i  <= pusi;
    @(posedge ref_clk_i);
    pkt_valid_i <= 1'b0;
    pkt_pid_i   <= ~pid;
    #1 check("mac_start", mac_start_o, exp);
  endtask

  task automatic send_ie(input logic [IUC_W-1:0] iuc, input logic [SID_W-1:0] sid,
                         input logic [MS_W-1:0] slot);
    @(posedge ref_clk_i);
    ie_valid_i <= 1'b1;
    ie_i       <= '{iuc: iuc, sid: sid, mslot: slot};
    @(posedge ref_clk_i);
    ie_valid_i <= 1'b0;
    ie_i       <= ~ie_i;
  endtask

  task automatic burst(input logic [IUC_W-1:0] iuc, input logic [SID_W-1:0] sid,
                       input logic [TS_W-1:0] off, input logic rng);
    logic [MS_W-1:0] slot;
    @(negedge ref_clk_i);
    slot = mslot_o + 32'h3;
    send_ie(iuc, sid, slot);
    wait_hi(1, 25000);
    check("launch", he_ts - ((slot << 8) - off) + 32'h2 <= 32'h4, 1'b1);
    check("tx_sid", tx_sid_o, sid);
    check("tx_iuc", tx_iuc_o, iuc);
    check("tx_profile", tx_profile_o, iuc + 4'h7);
    check("tx_ranging", tx_ranging_o, rng);
  endtask

  always @(negedge ref_clk_i) begin
    if (tx_start_o === 1'b1) begin
      n_tx++;
      check("tx synced", synced_o, 1'b1);
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    reg_read(REG_FIX_DLY);
    check("fix_dly reset", d, FIX_DLY_RST);
    reg_read(REG_TOL);
    check("tol reset", d, TOL_RST);
    reg_read(8'h24);
    check("unmapped", d, 32'h0);
    repeat (900) @(posedge ref_clk_i);
    reg_read(REG_STATUS);
    check("state phy wait", d[3:0], 4'h0);
    send_pkt(PID_MAC_DEF, 1'b1, 1'b0);
    send_ie(IUC_INIT_MAINT, SID_UNINIT, 32'h0);
    phy_i <= '1;
    repeat (3) @(posedge ref_clk_i);
    send_pkt(PID_MAC_DEF, 1'b1, 1'b1);
    send_pkt(PID_MAC_DEF, 1'b0, 1'b0);
    send_pkt(PID_MAC_DEF ^ 13'h1, 1'b1, 1'b0);
    wait_hi(0, 1000);
    ts0 = sync_ts_i;
    repeat (4) @(negedge ref_clk_i);
    check("sync after one", synced_o, 1'b0);
    reg_read(REG_LOCAL_TS);
    check("ts reload", d - ts0 <= 32'h1, 1'b1);
    wait_hi(0, 1000);
    repeat (4) @(negedge ref_clk_i);
    check("sync after two", synced_o, 1'b1);
    reg_read(REG_STATUS);
    check("state ucd wait", d[3:0], 4'h2);
    check("no early burst", n_tx, 0);
    reg_write(REG_CTRL, 32'h0000_0000);
    @(negedge ref_clk_i);
    check("enable off", synced_o, 1'b0);
    reg_read(REG_CTRL);
    check("ctrl readback", d, 32'h0000_0000);
    reg_write(REG_CTRL, 32'h0000_0001);
    @(negedge ref_clk_i);
    check("enable on", synced_o, 1'b1);
    reg_write(REG_FIX_DLY, 32'h0000_0123);
    for (int i = 3; i < 6; i++) begin
      @(posedge ref_clk_i);
      ucd_prof_we_i  <= 1'b1;
      ucd_prof_iuc_i <= 4'(i);
      ucd_prof_i     <= 4'(i + 7);
    end
    @(posedge ref_clk_i);
    ucd_prof_we_i <= 1'b0;
    ucd_valid_i   <= 1'b1;
    @(posedge ref_clk_i);
    ucd_valid_i <= 1'b0;
    reg_read(REG_OFFSET);
    check("initial offset", d, 32'h0000_0123);
    @(negedge ref_clk_i);
    check("mslot map", (he_ts >> 8) - mslot_o + 32'h1 <= 32'h2, 1'b1);
    check("mslot top", mslot_o[31:24], 8'h00);
    burst(IUC_INIT_MAINT, SID_UNINIT, 32'h0000_0123, 1'b1);
    wait_hi(2, 200);
    repeat (3) @(negedge ref_clk_i);
    reg_read(REG_SID);
    check("temp sid", d, 32'h0000_0155);
    reg_read(REG_OFFSET);
    check("offset fix", d, 32'h0000_0133);
    check("power adj", tx_power_adj_o, 8'h05);
    check("freq adj", tx_freq_adj_o, 16'h0100);
    reg_read(REG_STATUS);
    check("state sta wait", d[3:0], 4'h6);
    send_ie(IUC_STA_MAINT, 14'h00AA, mslot_o + 32'h2);
    burst(IUC_STA_MAINT, 14'h0155, 32'h0000_0133, 1'b1);
    wait_hi(2, 200);
    repeat (3) @(negedge ref_clk_i);
    check("ranged", ranged_o, 1'b1);
    burst(4'h5, 14'h0155, 32'h0000_0143, 1'b0);
    sync_en <= 1'b0;
    repeat (LOST + 500) @(negedge ref_clk_i);
    check("sync lost", synced_o, 1'b0);
    reg_read(REG_STATUS);
    check("state reacquire", d[3:0], 4'h1);
    check("burst count", n_tx, 3);
    summarize();
  end

  initial begin
    repeat (90000) @(posedge ref_clk_i);
    miscompares++;
    summarize();
  end
endmodule
